/* rtl/lcgc_global_ctrl.sv */
// Global nets, oscillators, I/O cells and configuration control around one logic block.
`timescale 1ns/10ps
`default_nettype none
`include "lcgc_defs.svh"
module lcgc_global_ctrl #(
    parameter logic [15:0] SLOW_HALF = `LCGC_SLOW_HALF,
    parameter logic [15:0] FAST_HALF = `LCGC_FAST_HALF
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic config_active_i,
    input wire logic [`LCGC_NETS-1:0] net_en_i,
    input wire logic [`LCGC_PINS-1:0] pin_in_i,
    input wire logic [`LCGC_PINS-1:0] gpio_out_i,
    input wire logic [`LCGC_PINS-1:0] gpio_oe_n_i,
    input wire logic fab_clk_i,
    input wire logic fab_ce_i,
    input wire logic fab_sr_i,
    input wire lcgc_pkg::lcgc_cell_in_t fab_in_i,
    input wire logic carry_i,
    input wire lcgc_pkg::lcgc_blk_cfg_t cfg_i,
    output logic [`LCGC_NETS-1:0] gnet_o,
    output logic float_o,
    output logic glb_rst_o,
    output logic [`LCGC_PINS-1:0] io_out_o,
    output logic [`LCGC_PINS-1:0] io_oe_n_o,
    output logic [`LCGC_PINS-1:0] gpio_in_o,
    output logic [`LCGC_CELLS-1:0] cell_out_o,
    output logic [`LCGC_CELLS-1:0] ff_o,
    output logic carry_out_o
);
    localparam logic [15:0] HALF [2] = '{SLOW_HALF, FAST_HALF};

    // Maps a dedicated pin to the global net it can drive.
    function automatic logic [2:0] pin_net(input int p);
        logic [17:0] map;
        map = `LCGC_PIN_NET_MAP;
        return map[3*p +: 3];
    endfunction : pin_net

    logic [1:0] osc_lvl_r;
    logic [1:0] osc_tick;
    logic [`LCGC_NETS-1:0] net_src;
    logic [`LCGC_NETS-1:0] gnet_r;
    logic [`LCGC_PINS-1:0] pin_glb;
    logic float_r;
    logic glb_rst_r;
    logic [`LCGC_PINS-1:0] io_out_r;
    logic [`LCGC_PINS-1:0] io_oe_n_r;
    logic [`LCGC_PINS-1:0] gpio_in_r;
    logic [`LCGC_CELLS-1:0] cell_out_r;
    logic carry_out_r;
    logic [`LCGC_CELLS-1:0] blk_cell;
    logic [`LCGC_CELLS-1:0] blk_ff;
    logic blk_carry;

    // Both oscillators are modelled as dividers of the one system clock.
    // A half period below one cycle is not reachable at this clock rate.
    for (genvar o = 0; o < 2; o++) begin : g_osc
        logic [15:0] cnt_r;
        assign osc_tick[o] = (cnt_r == HALF[o] - 16'h0001);
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                cnt_r <= 16'h0000;
            end else if (osc_tick[o]) begin
                cnt_r <= 16'h0000;
            end else begin
                cnt_r <= cnt_r + 16'h0001;
            end
        end
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                osc_lvl_r[o] <= 1'b0;
            end else if (osc_tick[o]) begin
                osc_lvl_r[o] <= ~osc_lvl_r[o];
            end
        end
    end

    assign net_src[`LCGC_NET_SLOW] = osc_lvl_r[0]; // RULE_15
    assign net_src[`LCGC_NET_FAST] = osc_lvl_r[1]; // RULE_15

    for (genvar p = 0; p < `LCGC_PINS; p++) begin : g_pin
        assign net_src[pin_net(p)] = pin_in_i[p]; // RULE_14
        assign pin_glb[p] = net_en_i[pin_net(p)]; // RULE_10
    end

    // A disabled net idles low so that no block sees a spurious clock edge.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gnet_r <= 8'h00;
        end else begin
            gnet_r <= net_en_i & net_src; // RULE_10 RULE_14 RULE_15
        end
    end

    // Power-up is treated as configuration in progress.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            float_r <= 1'b1;
        end else begin
            float_r <= config_active_i; // RULE_16
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            glb_rst_r <= 1'b1;
        end else begin
            glb_rst_r <= config_active_i; // RULE_17
        end
    end

    // A pin that feeds a global net is an input only.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            io_oe_n_r <= 6'h3f;
        end else if (config_active_i) begin
            io_oe_n_r <= 6'h3f; // RULE_16
        end else begin
            io_oe_n_r <= gpio_oe_n_i | pin_glb; // RULE_10
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            io_out_r <= 6'h00;
        end else if (config_active_i) begin
            io_out_r <= 6'h00; // RULE_17
        end else begin
            io_out_r <= gpio_out_i; // RULE_10
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gpio_in_r <= 6'h00;
        end else if (config_active_i) begin
            gpio_in_r <= 6'h00; // RULE_17
        end else begin
            gpio_in_r <= pin_in_i; // RULE_10
        end
    end

    lcgc_logic_block u_blk (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .glb_rst_i(glb_rst_r),
        .gnet_i(gnet_r),
        .fab_clk_i(fab_clk_i),
        .fab_ce_i(fab_ce_i),
        .fab_sr_i(fab_sr_i),
        .fab_in_i(fab_in_i),
        .carry_i(carry_i),
        .cfg_i(cfg_i),
        .cell_o(blk_cell),
        .ff_o(blk_ff),
        .carry_o(blk_carry)
    );

    // Registering the cell outputs costs one cycle of latency but keeps
    // every port of the tile free of combinational paths.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cell_out_r <= 8'h00;
        end else begin
            cell_out_r <= blk_cell; // RULE_08
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            carry_out_r <= 1'b0;
        end else begin
            carry_out_r <= blk_carry; // RULE_07
        end
    end

    assign gnet_o = gnet_r;
    assign float_o = float_r;
    assign glb_rst_o = glb_rst_r;
    assign io_out_o = io_out_r;
    assign io_oe_n_o = io_oe_n_r;
    assign gpio_in_o = gpio_in_r;
    assign cell_out_o = cell_out_r;
    assign ff_o = blk_ff;
    assign carry_out_o = carry_out_r;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_cfg_end;
        config_active_i ##1 !config_active_i;
    endsequence
    sequence s_released;
        glb_rst_o && float_o ##1 !glb_rst_o && !float_o;
    endsequence

    property p_float_cfg;
        config_active_i |=> float_o && io_oe_n_o == 6'h3f;
    endproperty
    a_float_cfg: assert property (p_float_cfg) else $error("pins driven in configuration"); // RULE_16

    property p_rst_cfg;
        config_active_i |=> glb_rst_o && gpio_in_o == 6'h00;
    endproperty
    a_rst_cfg: assert property (p_rst_cfg) else $error("global reset missing"); // RULE_17

    property p_release;
        s_cfg_end |-> s_released;
    endproperty
    a_release: assert property (p_release) else $error("release sequence wrong"); // RULE_19

    property p_wake_ff;
        glb_rst_o |=> ff_o == 8'h00;
    endproperty
    a_wake_ff: assert property (p_wake_ff) else $error("flops not at wake-up state"); // RULE_18

    property p_pin_net;
        net_en_i[0] |=> gnet_o[0] == $past(pin_in_i[0]);
    endproperty
    a_pin_net: assert property (p_pin_net) else $error("net 0 not from its pin"); // RULE_14

    property p_pin_net7;
        net_en_i[7] |=> gnet_o[7] == $past(pin_in_i[5]);
    endproperty
    a_pin_net7: assert property (p_pin_net7) else $error("net 7 not from its pin"); // RULE_14

    property p_osc;
        net_en_i[4] && net_en_i[5] |=> gnet_o[5:4] == $past(osc_lvl_r);
    endproperty
    a_osc: assert property (p_osc) else $error("oscillator nets wrong"); // RULE_15

    property p_net_off;
        !net_en_i[2] |=> !gnet_o[2];
    endproperty
    a_net_off: assert property (p_net_off) else $error("disabled net not idle"); // RULE_10

    property p_gpio;
        !config_active_i && !pin_glb[1] && !gpio_oe_n_i[1] |=>
            !io_oe_n_o[1] && io_out_o[1] == $past(gpio_out_i[1]);
    endproperty
    a_gpio: assert property (p_gpio) else $error("free pin lost its I/O use"); // RULE_10

    property p_glb_pin_in;
        pin_glb[3] |=> io_oe_n_o[3];
    endproperty
    a_glb_pin_in: assert property (p_glb_pin_in) else $error("global pin driven"); // RULE_10

    property p_cell_reg;
        1'b1 |=> cell_out_o == $past(blk_cell);
    endproperty
    a_cell_reg: assert property (p_cell_reg) else $error("cell output path wrong"); // RULE_08

    // Every dedicated pin reaches its own net one cycle later, never a neighbour's.
    property p_pin_net1;
        net_en_i[1] |=> gnet_o[1] == $past(pin_in_i[1]);
    endproperty
    a_pin_net1: assert property (p_pin_net1) else $error("net 1 not from its pin"); // RULE_14

    property p_pin_net2;
        net_en_i[2] |=> gnet_o[2] == $past(pin_in_i[2]);
    endproperty
    a_pin_net2: assert property (p_pin_net2) else $error("net 2 not from its pin"); // RULE_14

    property p_pin_net3;
        net_en_i[3] |=> gnet_o[3] == $past(pin_in_i[3]);
    endproperty
    a_pin_net3: assert property (p_pin_net3) else $error("net 3 not from its pin"); // RULE_14

    property p_pin_net6;
        net_en_i[6] |=> gnet_o[6] == $past(pin_in_i[4]);
    endproperty
    a_pin_net6: assert property (p_pin_net6) else $error("net 6 not from its pin"); // RULE_14

    // A net that was not enabled on the previous edge must read low, whatever its source does.
    property p_net_mask;
        1'b1 |=> (gnet_o & ~$past(net_en_i)) == 8'h00;
    endproperty
    a_net_mask: assert property (p_net_mask) else $error("net active while disabled"); // RULE_10

    property p_osc_off;
        !net_en_i[5] |=> !gnet_o[5];
    endproperty
    a_osc_off: assert property (p_osc_off) else $error("fast net not idle"); // RULE_15

    // Outside configuration a pin is plain I/O unless a net has claimed it as an input.
    property p_claim;
        !config_active_i |=> io_oe_n_o == $past(gpio_oe_n_i | pin_glb);
    endproperty
    a_claim: assert property (p_claim) else $error("pin claim wrong"); // RULE_10

    property p_gpio_in;
        !config_active_i |=> gpio_in_o == $past(pin_in_i);
    endproperty
    a_gpio_in: assert property (p_gpio_in) else $error("pin input not returned"); // RULE_10

    // While the pins float nothing is driven toward them and nothing is read back.
    property p_float_hold;
        float_o |-> io_oe_n_o == 6'h3f;
    endproperty
    a_float_hold: assert property (p_float_hold) else $error("pin not floated"); // RULE_16

    property p_io_quiet;
        float_o |-> io_out_o == 6'h00 && gpio_in_o == 6'h00;
    endproperty
    a_io_quiet: assert property (p_io_quiet) else $error("pin flops not reset"); // RULE_17

    // The global reset lags configuration by one edge, so the flops clear one edge later still.
    sequence s_cfg_held;
        config_active_i ##1 config_active_i;
    endsequence
    property p_ff_cfg;
        s_cfg_held |=> ff_o == 8'h00;
    endproperty
    a_ff_cfg: assert property (p_ff_cfg) else $error("flops not cleared"); // RULE_17

    // Each oscillator flips its level on its divider tick, and the tick lasts one cycle.
    property p_slow_flip;
        osc_tick[0] |=> osc_lvl_r[0] != $past(osc_lvl_r[0]);
    endproperty
    a_slow_flip: assert property (p_slow_flip) else $error("slow level did not flip"); // RULE_15

    property p_fast_flip;
        osc_tick[1] |=> osc_lvl_r[1] != $past(osc_lvl_r[1]);
    endproperty
    a_fast_flip: assert property (p_fast_flip) else $error("fast level did not flip"); // RULE_15

    property p_slow_pulse;
        osc_tick[0] |=> !osc_tick[0];
    endproperty
    a_slow_pulse: assert property (p_slow_pulse) else $error("slow tick too long"); // RULE_15

    property p_fast_pulse;
        osc_tick[1] |=> !osc_tick[1];
    endproperty
    a_fast_pulse: assert property (p_fast_pulse) else $error("fast tick too long"); // RULE_15

    // The fast carry leaves the tile one cycle after the block produces it.
    property p_carry_reg;
        1'b1 |=> carry_out_o == $past(blk_carry);
    endproperty
    a_carry_reg: assert property (p_carry_reg) else $error("carry out path wrong"); // RULE_07
endmodule : lcgc_global_ctrl
`default_nettype wire

/* rtl/lcgc_defs.svh */
// Constants of the logic cell array and its global control.
// Operation
// RULE_01: Eight cells per block, one table, one flop.
// RULE_02: Table is any four-input function, 16x1.
// RULE_03: D flop with optional enable and set/reset.
// RULE_04: One enable shared by block cells.
// RULE_05: One shared set/reset, asynchronous or synchronous.
// RULE_06: Block clock from global net or fabric.
// RULE_07: Fast carry in and out per cell.
// RULE_08: Cell output is table or flop.
// RULE_09: Unused set/reset never moves the flop.
// RULE_10: Six global pins, otherwise general I/O.
// RULE_11: Any global net may clock any block.
// RULE_12: Up to four global nets feed tables.
// RULE_13: Even nets set/reset, odd nets enable.
// RULE_14: Nets 7,6,3..0 driven from matching pins.
// RULE_15: Net 4 slow oscillator, net 5 fast.
// RULE_16: Float control holds pins off during configuration.
// RULE_17: Global reset holds all flops during configuration.
// RULE_18: Wake-up state is always the reset value.
// RULE_19: Capture starts on first enabled edge after.
`ifndef LCGC_DEFS_SVH
`define LCGC_DEFS_SVH
`define LCGC_CELLS 8
`define LCGC_NETS 8
`define LCGC_PINS 6
`define LCGC_TAPS 4
`define LCGC_LUT_W 16
`define LCGC_NET_SLOW 4
`define LCGC_NET_FAST 5
`define LCGC_PIN_NET_MAP 18'h3e688
`define LCGC_SLOW_HALF 16'h0200
`define LCGC_FAST_HALF 16'h0002
`define LCGC_FF_RST 1'b0
`endif

/* rtl/lcgc_pkg.sv */
// Types carried between the global control and the logic block.
`include "lcgc_defs.svh"
package lcgc_pkg;
    typedef logic [`LCGC_CELLS-1:0][`LCGC_TAPS-1:0] lcgc_cell_in_t;
    typedef struct packed {
        logic [`LCGC_CELLS-1:0][`LCGC_LUT_W-1:0] lut;
        logic [`LCGC_CELLS-1:0] out_reg;
        logic [`LCGC_CELLS-1:0] set_type;
        logic [`LCGC_CELLS-1:0] cin_i3;
        logic clk_fab;
        logic [2:0] clk_sel;
        logic ce_used;
        logic ce_glb;
        logic [1:0] ce_sel;
        logic sr_used;
        logic sr_glb;
        logic [1:0] sr_sel;
        logic sr_async;
        logic [`LCGC_TAPS-1:0] tap_use;
        logic [`LCGC_TAPS-1:0][2:0] tap_sel;
    } lcgc_blk_cfg_t;
endpackage : lcgc_pkg

/* rtl/lcgc_logic_block.sv */
// Logic block of eight cells sharing clock, enable and set/reset.
`timescale 1ns/10ps
`default_nettype none
`include "lcgc_defs.svh"
module lcgc_logic_block (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic glb_rst_i,
    input wire logic [`LCGC_NETS-1:0] gnet_i,
    input wire logic fab_clk_i,
    input wire logic fab_ce_i,
    input wire logic fab_sr_i,
    input wire lcgc_pkg::lcgc_cell_in_t fab_in_i,
    input wire logic carry_i,
    input wire lcgc_pkg::lcgc_blk_cfg_t cfg_i,
    output logic [`LCGC_CELLS-1:0] cell_o,
    output logic [`LCGC_CELLS-1:0] ff_o,
    output logic carry_o
);
    logic clk_src;
    logic clk_src_d_r;
    logic tick;
    logic ce;
    logic sr;
    logic sr_hit;
    logic cap;
    logic [`LCGC_CELLS:0] cy;
    logic [`LCGC_TAPS-1:0] tap;
    logic [`LCGC_CELLS-1:0] lut_q;
    logic [`LCGC_CELLS-1:0] ff_r;

    // The block clock is a sampled level; its rising edge is the capture tick.
    assign clk_src = cfg_i.clk_fab ? fab_clk_i : gnet_i[cfg_i.clk_sel]; // RULE_06 RULE_11
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clk_src_d_r <= 1'b0;
        end else begin
            clk_src_d_r <= clk_src;
        end
    end
    assign tick = clk_src & ~clk_src_d_r;
    assign ce = !cfg_i.ce_used | (cfg_i.ce_glb ? gnet_i[{cfg_i.ce_sel, 1'b1}] : fab_ce_i); // RULE_04 RULE_13
    assign sr = cfg_i.sr_used & (cfg_i.sr_glb ? gnet_i[{cfg_i.sr_sel, 1'b0}] : fab_sr_i); // RULE_05 RULE_09 RULE_13
    // Asynchronous mode acts without waiting for the block clock edge.
    assign sr_hit = sr & (cfg_i.sr_async | tick); // RULE_05
    assign cap = tick & ce; // RULE_04
    assign cy[0] = carry_i; // RULE_07
    assign carry_o = cy[`LCGC_CELLS]; // RULE_07
    assign ff_o = ff_r;

    for (genvar j = 0; j < `LCGC_TAPS; j++) begin : g_tap
        assign tap[j] = gnet_i[cfg_i.tap_sel[j]]; // RULE_12
    end

    for (genvar g = 0; g < `LCGC_CELLS; g++) begin : g_cell // RULE_01
        logic [`LCGC_TAPS-1:0] a;
        logic [3:0] adr;
        for (genvar j = 0; j < `LCGC_TAPS; j++) begin : g_in
            assign a[j] = cfg_i.tap_use[j] ? tap[j] : fab_in_i[g][j]; // RULE_12
        end
        assign adr = {cfg_i.cin_i3[g] ? cy[g] : a[3], a[2:0]};
        assign lut_q[g] = cfg_i.lut[g][adr]; // RULE_02
        assign cy[g+1] = (a[1] & a[2]) | (a[1] & cy[g]) | (a[2] & cy[g]); // RULE_07
        assign cell_o[g] = cfg_i.out_reg[g] ? ff_r[g] : lut_q[g]; // RULE_08
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                ff_r[g] <= `LCGC_FF_RST;
            end else if (glb_rst_i) begin
                ff_r[g] <= `LCGC_FF_RST; // RULE_17 RULE_18
            end else if (sr_hit) begin
                ff_r[g] <= cfg_i.set_type[g]; // RULE_05
            end else if (cap) begin
                ff_r[g] <= lut_q[g]; // RULE_03 RULE_19
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_hold;
        !glb_rst_i && !sr_hit && !cap |=> ff_o == $past(ff_o);
    endproperty
    a_hold: assert property (p_hold) else $error("cell flop moved without cause"); // RULE_09
    property p_sr_async;
        cfg_i.sr_async && sr && !glb_rst_i |=> ff_o == $past(cfg_i.set_type);
    endproperty
    a_sr_async: assert property (p_sr_async) else $error("set/reset not applied"); // RULE_05
    property p_cap;
        cap && !sr_hit && !glb_rst_i |=> ff_o == $past(lut_q);
    endproperty
    a_cap: assert property (p_cap) else $error("enabled edge did not capture"); // RULE_03
    property p_wake;
        glb_rst_i |=> ff_o == '0;
    endproperty
    a_wake: assert property (p_wake) else $error("wake-up state not reset"); // RULE_18
endmodule : lcgc_logic_block
`default_nettype wire

/* verification/lcgc_pad_model.sv */
// Pad model: outside drivers and pull-ups on the six dedicated global pins.
`timescale 1ns/10ps
`default_nettype none
module lcgc_pad_model (
    input wire logic [5:0] drv_i,
    input wire logic [5:0] drv_oe_n_i,
    input wire logic [5:0] ext_i,
    input wire logic [5:0] ext_en_i,
    output logic [5:0] pin_o
);
    // A pad that nobody drives goes to its pull-up and never keeps its last level.
    assign pin_o = (~drv_oe_n_i & drv_i) | (drv_oe_n_i & ((ext_en_i & ext_i) | ~ext_en_i));
endmodule : lcgc_pad_model
`default_nettype wire

/* verification/lcgc_global_ctrl_test.sv */
// Self-checking bench for the global control and its logic block.
`timescale 1ns/10ps
`default_nettype none
module lcgc_global_ctrl_test;
    typedef struct {int sel; logic [8:0] exp; int due;} lcgc_note_t;
    logic clk_i = 1'b0;
    logic rst_n = 1'b0, cfa = 1'b1, fck = 1'b0, fce = 1'b0, fsr = 1'b0, cin = 1'b0;
    logic [7:0] ne = 8'h00, gn, co, ff;
    logic [5:0] go = 6'h00, gon = 6'h3f, ext = 6'h00, een = 6'h3f, ioo, ion, gi, oe, pl;
    wire logic [5:0] pin;
    logic flt, grs, cy;
    lcgc_pkg::lcgc_cell_in_t fin = '0, fa;
    lcgc_pkg::lcgc_blk_cfg_t cfg = '0, c;
    lcgc_note_t q[$], n;
    logic [31:0] seed = 32'h0000001b, v;
    logic [8:0] t, e;
    int cyc = 0, err_total = 0, n_tests = 0, nf, ns;
    string nm[7] = '{"gnet", "cell_out", "ff", "io_oe_n", "-", "gpio_in", "float_rst"};
    localparam int PNET[6] = '{0, 1, 2, 3, 6, 7};
    // Per step: enable, set/reset, async, used, tick, expected (0 old, 1 table, 2 set value).
    logic [6:0] st[7] = '{7'b0001100, 7'b1001101, 7'b1101001, 7'b1101110, 7'b1001101,
        7'b0111010, 7'b1100101};

    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) cyc <= cyc + 1;

    lcgc_global_ctrl #(.SLOW_HALF(16'h0004), .FAST_HALF(16'h0002)) u_dut (
        .clk_i(clk_i), .rst_n_i(rst_n), .config_active_i(cfa), .net_en_i(ne),
        .pin_in_i(pin), .gpio_out_i(go), .gpio_oe_n_i(gon), .fab_clk_i(fck),
        .fab_ce_i(fce), .fab_sr_i(fsr), .fab_in_i(fin), .carry_i(cin), .cfg_i(cfg),
        .gnet_o(gn), .float_o(flt), .glb_rst_o(grs), .io_out_o(ioo), .io_oe_n_o(ion),
        .gpio_in_o(gi), .cell_out_o(co), .ff_o(ff), .carry_out_o(cy));
    lcgc_pad_model u_pad (.drv_i(ioo), .drv_oe_n_i(ion), .ext_i(ext), .ext_en_i(een),
        .pin_o(pin));

    function automatic logic [31:0] rnd();
        repeat (32) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction : rnd

    // Reference of the eight tables and the carry chain, carry out in bit 8.
    function automatic logic [8:0] model(lcgc_pkg::lcgc_blk_cfg_t m,
        lcgc_pkg::lcgc_cell_in_t f, logic [7:0] g, logic ci);
        logic [3:0] a;
        logic [8:0] r;
        for (int k = 0; k < 8; k++) begin
            for (int j = 0; j < 4; j++) a[j] = m.tap_use[j] ? g[m.tap_sel[j]] : f[k][j];
            r[k] = m.lut[k][{m.cin_i3[k] ? ci : a[3], a[2:0]}];
            ci = (a[1] & a[2]) | (ci & (a[1] | a[2]));
        end
        r[8] = ci;
        return r;
    endfunction : model

    function automatic logic [8:0] obs(int s);
        case (s)
            0: return {1'b0, gn};
            1: return {cy, co};
            2: return {1'b0, ff};
            3: return {3'b0, ion};
            5: return {3'b0, gi};
            default: return {7'b0, flt, grs};
        endcase
    endfunction : obs

    task automatic chk(string w, logic [8:0] x, logic [8:0] s);
        n_tests++;
        if (s !== x) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", w, x, s);
        end
    endtask : chk

    // Results are looked at five edges after the inputs change, once every path has settled.
    task automatic note(int s, logic [8:0] x);
        q.push_back('{s, x, cyc + 6});
    endtask : note

    task automatic hold();
        repeat (6) @(posedge clk_i);
    endtask : hold

    task automatic tick();
        fck <= 1'b1;
        hold();
        fck <= 1'b0;
        hold();
    endtask : tick

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : finish_test

    always @(negedge clk_i) begin
        while (q.size() > 0 && q[0].due == cyc) begin
            n = q.pop_front();
            chk(nm[n.sel], n.exp, obs(n.sel));
        end
    end

    always @(posedge clk_i) begin
        if (cyc == 3000) begin
            err_total++;
            finish_test();
        end
    end

    initial begin
        c = '0;
        c.lut = '1;
        c.set_type = 8'hff;
        c.out_reg = 8'hff;
        c.clk_fab = 1'b1;
        cfg = c;
        @(posedge clk_i);
        note(6, 9'h003);
        note(3, 9'h03f);
        repeat (5) @(posedge clk_i);
        rst_n <= 1'b1;
        note(2, 9'h000);
        tick();
        cfa <= 1'b0;
        note(6, 9'h000);
        note(2, 9'h000);
        hold();
        note(2, 9'h0ff);
        tick();
        c.out_reg = 8'h00;
        for (int i = 0; i < 20; i++) begin
            v = rnd();
            oe = v[31:26] | {v[7:6], v[3:0]};
            pl = (~oe & v[25:20]) | (oe & ((v[19:14] & v[13:8]) | ~v[19:14]));
            e = {1'b0, v[7:6] & pl[5:4], 2'b00, v[3:0] & pl[3:0]};
            ne <= v[7:0] & 8'hcf;
            ext <= v[13:8];
            een <= v[19:14];
            go <= v[25:20];
            gon <= v[31:26];
            c.lut = {rnd(), rnd(), rnd(), rnd()};
            fa = rnd();
            v = rnd();
            c.cin_i3 = v[7:0];
            c.tap_use = v[11:8];
            c.tap_sel = v[23:12];
            cfg <= c;
            fin <= fa;
            cin <= v[24];
            note(0, e);
            note(3, {3'b0, oe});
            note(5, {3'b0, pl});
            note(1, model(c, fa, e[7:0], v[24]));
            hold();
        end
        c.out_reg = 8'hff;
        c.cin_i3 = 8'h00;
        c.tap_use = 4'h0;
        c.ce_used = 1'b1;
        c.set_type = 8'ha5;
        fa = rnd();
        t = model(c, fa, 8'h00, 1'b0);
        fin <= fa;
        cin <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            c.sr_async = st[i][4];
            c.sr_used = st[i][3];
            cfg <= c;
            fce <= st[i][6];
            fsr <= st[i][5];
            e = st[i][1] ? 9'h0a5 : st[i][0] ? {1'b0, t[7:0]} : 9'h0ff;
            note(2, e);
            note(1, {t[8], e[7:0]});
            if (st[i][2]) tick();
            else hold();
        end
        c.clk_fab = 1'b0;
        c.ce_used = 1'b0;
        c.sr_used = 1'b0;
        fsr <= 1'b0;
        een <= 6'h3f;
        gon <= 6'h3f;
        ext <= 6'h00;
        for (int p = 0; p < 6; p++) begin
            c.clk_sel = PNET[p][2:0];
            fa = rnd();
            e = model(c, fa, 8'h00, 1'b0) & 9'h0ff;
            cfg <= c;
            ne <= 8'h01 << PNET[p];
            fin <= fa;
            hold();
            ext <= 6'h01 << p;
            note(2, e);
            hold();
            ext <= 6'h00;
        end
        c.clk_sel = 3'd0;
        c.ce_used = 1'b1;
        c.ce_glb = 1'b1;
        c.ce_sel = 2'd0;
        fa = rnd();
        t = model(c, fa, 8'h00, 1'b0);
        cfg <= c;
        ne <= 8'h43;
        fin <= fa;
        hold();
        ext <= 6'h01;
        note(2, e);
        hold();
        ext <= 6'h02;
        hold();
        ext <= 6'h03;
        note(2, {1'b0, t[7:0]});
        hold();
        c.sr_used = 1'b1;
        c.sr_glb = 1'b1;
        c.sr_sel = 2'd3;
        c.sr_async = 1'b1;
        cfg <= c;
        ext <= 6'h13;
        note(2, 9'h0a5);
        hold();
        ne <= 8'h30;
        hold();
        nf = 0;
        ns = 0;
        @(negedge clk_i);
        e[1:0] = gn[5:4];
        repeat (32) begin
            @(negedge clk_i);
            nf += int'(gn[5] !== e[1]);
            ns += int'(gn[4] !== e[0]);
            e[1:0] = gn[5:4];
        end
        chk("fast_osc", 9'h001, {8'h00, nf >= 10 && nf <= 16});
        chk("slow_osc", 9'h001, {8'h00, ns >= 6 && ns <= 8});
        @(posedge clk_i);
        cfa <= 1'b1;
        note(6, 9'h003);
        note(3, 9'h03f);
        note(2, 9'h000);
        hold();
        cfa <= 1'b0;
        hold();
        finish_test();
    end
endmodule : lcgc_global_ctrl_test
`default_nettype wire
